// file: inc/arcs_link_if.sv
// Purpose: Pins between the converter end and the host end
// Assumes: Both ends clocked by the same CORE_CLK
// Notes:   Resolves the open-drain recalibration line with its pull-up
`timescale 1ns/1ps
interface arcs_link_if;

  // Open-drain recalibration request line
  logic        recal_dev_o;
  logic        recal_dev_oe_n;
  logic        recal_host_o;
  logic        recal_host_oe_n;
  logic        recal_low;
  // Serial data output pin, host side enable only
  logic        sdo_host_oe_n;
  // Data and output clock
  logic [15:0] sample_data;
  logic        out_clk;
  // Status register access
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic        reg_ack;
  logic [7:0]  reg_rdata;
  // Divider override from the configuration port
  logic        div_ovr_en;
  logic [1:0]  div_ovr_ratio;

  // Pull-up wins unless someone drives low
  assign recal_low = !((!recal_dev_oe_n && !recal_dev_o) || (!recal_host_oe_n && !recal_host_o));

  modport dev (
    input  recal_low, reg_rd, reg_addr, div_ovr_en, div_ovr_ratio,
    output recal_dev_o, recal_dev_oe_n, sample_data, out_clk, reg_ack, reg_rdata
  );

  modport host (
    input  recal_low, sample_data, out_clk, reg_ack, reg_rdata,
    output recal_host_o, recal_host_oe_n, sdo_host_oe_n, reg_rd, reg_addr, div_ovr_en, div_ovr_ratio
  );

endinterface

// file: inc/arcs_pkg.sv
// Purpose: Shared constants for the converter calibration sequencer and its host
// Assumes: One sample clock CORE_CLK at 25 MHz shared by both ends
// Notes:   Times are kept in ms and turned into cycle counts here
package arcs_pkg;

  // Clock rate and calibration times
  localparam int CLK_HZ         = 25_000_000;
  localparam int CAL_NOM_MS     = 200;
  localparam int CAL_MAX_MS     = 550;
  localparam int CAL_NOM_CYC    = CAL_NOM_MS * (CLK_HZ / 1000);
  localparam int CAL_MAX_CYC    = CAL_MAX_MS * (CLK_HZ / 1000);
  localparam int TMO_MARGIN_CYC = 1024;
  localparam int CNT_W          = 24;

  // Data path
  localparam int          PIPE_LAT    = 10;
  localparam int          CORE_W      = 16;
  localparam logic [15:0] CAL_PATTERN = 16'hCCCC;

  // Device register file
  localparam logic [7:0] CAL_STATUS_OFS = 8'hB6;
  localparam int         CAL_DONE_BIT   = 0;

  // Divider ratio codes and toggle masks
  localparam logic [1:0] DIV_BY1   = 2'h0;
  localparam logic [1:0] DIV_BY2   = 2'h1;
  localparam logic [1:0] DIV_BY4   = 2'h2;
  localparam logic [1:0] DIV_MASK1 = 2'h0;
  localparam logic [1:0] DIV_MASK2 = 2'h1;
  localparam logic [1:0] DIV_MASK4 = 2'h3;

  // Host register map, byte addresses
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_DATA_OFS = 8'h08;
  localparam int         CTRL_START    = 0;
  localparam int         CTRL_OVR_EN   = 1;
  localparam int         CTRL_RATIO_LO = 2;
  localparam int         STAT_DONE     = 0;
  localparam int         STAT_BUSY     = 1;
  localparam int         STAT_TMO      = 2;
  localparam int         STAT_PAT      = 3;

  // Host timing
  localparam int RECAL_PULSE_CYC = 2;
  localparam int POLL_GAP_CYC    = 16;

  // Host sequencer states
  typedef enum logic [2:0] {
    H_WATCH = 3'b000,
    H_IDLE  = 3'b001,
    H_PULSE = 3'b010,
    H_POLL  = 3'b011,
    H_READ  = 3'b100
  } arcs_host_state_type;

endpackage

// file: logic/arcs_device.sv
// Purpose: Converter end: power-on hold, calibration sequence, data path, output clock
// Assumes: CORE_CLK is the sample clock; supply flags and strap are asynchronous pins
// Notes:   Calibration length is a parameter so simulation can shorten it
`timescale 1ns/1ps
module arcs_device #(
  parameter int CAL_CYCLES = arcs_pkg::CAL_NOM_CYC
) (
  // Clock and reset
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESET_N,
  // Link to the host
  arcs_link_if.dev                         LINK,
  // Supply detector flags, asynchronous
  input  wire logic                        AVDD_OK,
  input  wire logic                        DVDD_OK,
  // Divider strap pin, asynchronous
  input  wire logic [1:0]                  STRAP_RATIO,
  // Results of the two converter cores, one per cycle
  input  wire logic [arcs_pkg::CORE_W-1:0] CORE_A,
  input  wire logic [arcs_pkg::CORE_W-1:0] CORE_B
);

  localparam int LAT = arcs_pkg::PIPE_LAT;
  localparam int W   = arcs_pkg::CORE_W;

  typedef struct packed {
    logic                      line_s1;
    logic                      line_s2;
    logic                      line_q;
    logic                      av_s1;
    logic                      av_s2;
    logic                      dv_s1;
    logic                      dv_s2;
    logic [1:0]                strap_s1;
    logic [1:0]                strap_s2;
    logic                      por_oe_n;
    logic                      busy;
    logic [arcs_pkg::CNT_W-1:0] cal_cnt;
    logic                      status;
    logic [LAT-1:0][W-1:0]     pipe;
    logic [W-1:0]              dout;
    logic [1:0]                div_cnt;
    logic                      clk_out;
    logic                      ack;
    logic [7:0]                rdata;
  } arcs_dev_state_type;

  arcs_dev_state_type s_r;
  arcs_dev_state_type s_nxt;

  logic [W:0]  sum;
  logic        rise;
  logic        done_nxt;
  logic [1:0]  ratio;
  logic [1:0]  mask;

  // Whole next state in one place
  always_comb
  begin
    s_nxt    = s_r;
    sum      = {1'b0, CORE_A} + {1'b0, CORE_B};
    rise     = 1'b0;
    done_nxt = 1'b0;
    ratio    = arcs_pkg::DIV_BY1;
    mask     = arcs_pkg::DIV_MASK1;

    // Pin synchronisers; first stage feeds only the second
    s_nxt.line_s1  = LINK.recal_low;
    s_nxt.line_s2  = s_r.line_s1;
    s_nxt.line_q   = s_r.line_s2;
    s_nxt.av_s1    = AVDD_OK;
    s_nxt.av_s2    = s_r.av_s1;
    s_nxt.dv_s1    = DVDD_OK;
    s_nxt.dv_s2    = s_r.dv_s1;
    s_nxt.strap_s1 = STRAP_RATIO;
    s_nxt.strap_s2 = s_r.strap_s1;

    // Power-on detector: hold the line low until both supplies are good, then let go for good
    // Latched, so a later supply glitch cannot restart calibration on its own
    if (s_r.av_s2 && s_r.dv_s2)
    begin
      s_nxt.por_oe_n = 1'b1;
    end

    // Calibration run; a low line aborts it and restarts on release
    // Counter is loaded on the rise and runs down to zero, so busy lasts CAL_CYCLES cycles
    rise = s_r.line_s2 && !s_r.line_q;
    if (!s_r.line_s2)
    begin
      s_nxt.busy = 1'b0;
    end
    else if (rise)
    begin
      s_nxt.busy    = 1'b1;
      s_nxt.cal_cnt = arcs_pkg::CNT_W'(CAL_CYCLES - 1);
    end
    else if (s_r.busy)
    begin
      if (s_r.cal_cnt == '0)
      begin
        s_nxt.busy = 1'b0;
      end
      else
      begin
        s_nxt.cal_cnt = s_r.cal_cnt - 1'b1;
      end
    end
    done_nxt     = s_r.line_s2 && !s_nxt.busy;
    s_nxt.status = done_nxt;

    // Data pipeline; upper bits of the sum keep full scale in 16 bits
    // It keeps running during calibration, so real data follows the pattern at once
    // Dropping the low bit of the sum loses half an LSB; the trade keeps the bus 16 bits wide
    s_nxt.pipe = {s_r.pipe[LAT-2:0], sum[W:1]};
    if (!done_nxt)
    begin
      s_nxt.dout = arcs_pkg::CAL_PATTERN;
    end
    else
    begin
      s_nxt.dout = s_r.pipe[LAT-1];
    end

    // Divider ratio: configured value beats the strap
    if (LINK.div_ovr_en)
    begin
      ratio = LINK.div_ovr_ratio;
    end
    else
    begin
      ratio = s_r.strap_s2;
    end
    case (ratio)
      arcs_pkg::DIV_BY2: mask = arcs_pkg::DIV_MASK2;
      arcs_pkg::DIV_BY4: mask = arcs_pkg::DIV_MASK4;
      default:           mask = arcs_pkg::DIV_MASK1; // Unused code acts as ratio one
    endcase

    // Output clock; ratio one ignores the request line entirely
    // Counter cleared while held, so the first edge after release gives a rising out_clk
    if ((mask != arcs_pkg::DIV_MASK1) && !s_r.line_s2)
    begin
      s_nxt.clk_out = 1'b0;
      s_nxt.div_cnt = 2'h0;
    end
    else
    begin
      if ((s_r.div_cnt & mask) == 2'h0)
      begin
        s_nxt.clk_out = !s_r.clk_out;
      end
      s_nxt.div_cnt = s_r.div_cnt + 2'h1;
    end

    // Status register read, answered one cycle after the strobe
    // Every offset is answered; only the status offset carries the done bit, other offsets read zero rather than stale bits
    s_nxt.ack   = LINK.reg_rd;
    s_nxt.rdata = 8'h00;
    if (LINK.reg_rd && (LINK.reg_addr == arcs_pkg::CAL_STATUS_OFS))
    begin
      s_nxt.rdata[arcs_pkg::CAL_DONE_BIT] = s_r.status;
    end
  end

  // State register; all-zero reset means the line is held low from power-up
  // Synchronous reset, so RESET_N must be held across at least one CORE_CLK edge
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  // Open drain: the data bit is always low, only the enable moves
  assign LINK.recal_dev_o    = 1'b0;
  assign LINK.recal_dev_oe_n = s_r.por_oe_n;
  assign LINK.sample_data    = s_r.dout;
  assign LINK.out_clk        = s_r.clk_out;
  assign LINK.reg_ack        = s_r.ack;
  assign LINK.reg_rdata      = s_r.rdata;

endmodule

// file: logic/arcs_host.sv
// Purpose: Host end: watches power-on calibration, requests recalibration, polls status
// Assumes: Classic Wishbone slave on CORE_CLK; link signals share that clock
// Notes:   No status reads are issued while the power-on calibration runs
`timescale 1ns/1ps
module arcs_host #(
  parameter int TIMEOUT_CYCLES = arcs_pkg::CAL_MAX_CYC + arcs_pkg::TMO_MARGIN_CYC
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // Link to the converter
  arcs_link_if.host        LINK,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O
);

  typedef struct packed {
    arcs_pkg::arcs_host_state_type st;
    logic                          oe_n;
    logic [3:0]                    pulse_cnt;
    logic [7:0]                    poll_cnt;
    logic [arcs_pkg::CNT_W-1:0]    tmo_cnt;
    logic                          rd;
    logic [7:0]                    reg_addr;
    logic                          seen;
    logic                          done;
    logic                          tmo;
    logic                          pat;
    logic [15:0]                   last;
    logic                          ovr_en;
    logic [1:0]                    ratio;
    logic                          ack;
    logic [31:0]                   dat;
  } arcs_host_reg_type;

  arcs_host_reg_type s_r;
  arcs_host_reg_type s_nxt;

  logic hit;
  logic wr0;
  logic start_req;
  logic tmo_clr;

  // Bus slave, sequencer and status in one pass
  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.rd  = 1'b0;
    hit       = WB_CYC_I && WB_STB_I && !s_r.ack;
    wr0       = hit && WB_WE_I && WB_SEL_I[0];
    start_req = wr0 && (WB_ADR_I == arcs_pkg::HOST_CTRL_OFS) && WB_DAT_I[arcs_pkg::CTRL_START];
    tmo_clr   = wr0 && (WB_ADR_I == arcs_pkg::HOST_STAT_OFS) && WB_DAT_I[arcs_pkg::STAT_TMO];

    // Single-cycle acknowledge; unmapped reads give zero, writes there vanish
    if (hit)
    begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = 32'h0000_0000;
      if (WB_ADR_I == arcs_pkg::HOST_CTRL_OFS)
      begin
        s_nxt.dat[arcs_pkg::CTRL_OVR_EN]                          = s_r.ovr_en;
        s_nxt.dat[arcs_pkg::CTRL_RATIO_LO+1:arcs_pkg::CTRL_RATIO_LO] = s_r.ratio;
      end
      else if (WB_ADR_I == arcs_pkg::HOST_STAT_OFS)
      begin
        s_nxt.dat[arcs_pkg::STAT_DONE] = s_r.done;
        s_nxt.dat[arcs_pkg::STAT_BUSY] = (s_r.st != arcs_pkg::H_IDLE);
        s_nxt.dat[arcs_pkg::STAT_TMO]  = s_r.tmo;
        s_nxt.dat[arcs_pkg::STAT_PAT]  = s_r.pat;
      end
      else if (WB_ADR_I == arcs_pkg::HOST_DATA_OFS)
      begin
        s_nxt.dat[15:0] = s_r.last;
      end
    end
    if (wr0 && (WB_ADR_I == arcs_pkg::HOST_CTRL_OFS))
    begin
      s_nxt.ovr_en = WB_DAT_I[arcs_pkg::CTRL_OVR_EN];
      s_nxt.ratio  = WB_DAT_I[arcs_pkg::CTRL_RATIO_LO+1:arcs_pkg::CTRL_RATIO_LO];
    end

    // Watch the data words; the fixed pattern marks a running calibration
    s_nxt.pat  = (LINK.sample_data == arcs_pkg::CAL_PATTERN);
    s_nxt.last = LINK.sample_data;

    // Sequencer
    case (s_r.st)
      arcs_pkg::H_WATCH:
      begin
        // Pattern only, no register reads during power-on
        if (s_r.pat)
        begin
          s_nxt.seen = 1'b1;
        end
        if (s_r.seen && !s_r.pat)
        begin
          s_nxt.done = 1'b1;
          s_nxt.st   = arcs_pkg::H_IDLE;
        end
      end
      arcs_pkg::H_IDLE:
      begin
        if (start_req)
        begin
          s_nxt.oe_n      = 1'b0;
          s_nxt.pulse_cnt = 4'(arcs_pkg::RECAL_PULSE_CYC - 1);
          s_nxt.tmo_cnt   = arcs_pkg::CNT_W'(TIMEOUT_CYCLES - 1);
          s_nxt.done      = 1'b0;
          s_nxt.st        = arcs_pkg::H_PULSE;
        end
      end
      arcs_pkg::H_PULSE:
      begin
        if (s_r.pulse_cnt == 4'h0)
        begin
          s_nxt.oe_n     = 1'b1;
          s_nxt.poll_cnt = 8'(arcs_pkg::POLL_GAP_CYC - 1);
          s_nxt.st       = arcs_pkg::H_POLL;
        end
        else
        begin
          s_nxt.pulse_cnt = s_r.pulse_cnt - 4'h1;
        end
      end
      arcs_pkg::H_POLL:
      begin
        if (s_r.poll_cnt == 8'h00)
        begin
          s_nxt.rd = 1'b1;
          s_nxt.st = arcs_pkg::H_READ;
        end
        else
        begin
          s_nxt.poll_cnt = s_r.poll_cnt - 8'h01;
        end
      end
      arcs_pkg::H_READ:
      begin
        if (LINK.reg_ack)
        begin
          if (LINK.reg_rdata[arcs_pkg::CAL_DONE_BIT])
          begin
            s_nxt.done = 1'b1;
            s_nxt.st   = arcs_pkg::H_IDLE;
          end
          else
          begin
            s_nxt.poll_cnt = 8'(arcs_pkg::POLL_GAP_CYC - 1);
            s_nxt.st       = arcs_pkg::H_POLL;
          end
        end
      end
      default:
      begin
        s_nxt.st = arcs_pkg::H_IDLE;
      end
    endcase

    // Timeout sized for the longest calibration; it overrides the sequencer unless the sequencer returns to H_IDLE in the same cycle
    if (tmo_clr)
    begin
      s_nxt.tmo = 1'b0;
    end
    if ((s_r.st != arcs_pkg::H_IDLE) && (s_nxt.st != arcs_pkg::H_IDLE))
    begin
      if (s_r.tmo_cnt == '0)
      begin
        s_nxt.tmo  = 1'b1; // Set wins over a same-cycle clear
        s_nxt.oe_n = 1'b1;
        s_nxt.rd   = 1'b0;
        s_nxt.st   = arcs_pkg::H_IDLE;
      end
      else
      begin
        s_nxt.tmo_cnt = s_r.tmo_cnt - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      s_r          <= '0;
      s_r.oe_n     <= 1'b1;
      s_r.reg_addr <= arcs_pkg::CAL_STATUS_OFS;
      s_r.tmo_cnt  <= arcs_pkg::CNT_W'(TIMEOUT_CYCLES - 1);
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs from the state register
  assign LINK.recal_host_o    = 1'b0;
  assign LINK.recal_host_oe_n = s_r.oe_n;
  assign LINK.sdo_host_oe_n   = 1'b1;
  assign LINK.reg_rd          = s_r.rd;
  assign LINK.reg_addr        = s_r.reg_addr;
  assign LINK.div_ovr_en      = s_r.ovr_en;
  assign LINK.div_ovr_ratio   = s_r.ratio;
  assign WB_DAT_O             = s_r.dat;
  assign WB_ACK_O             = s_r.ack;

endmodule

// file: sim/adc_reset_calibration_sequencer_tb.sv
// Purpose: Self-checking bench joining converter end and host end
// Assumes: Calibration shortened to 200 cycles, host timeout to 2000
// Notes:   Core words are random from a fixed xorshift seed
`timescale 1ns/1ps
module adc_reset_calibration_sequencer_tb;
  localparam int CAL = 200;
  // Clock, reset and converter pins
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        avdd_ok  = 1'b0;
  logic        dvdd_ok  = 1'b0;
  logic [15:0] core_a   = 16'h0000;
  logic [15:0] core_b   = 16'h0000;
  // Wishbone master
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [7:0]  wb_adr   = 8'h00;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_dat   = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  // Checking state
  int          errors   = 0;
  int          checked  = 0;
  logic [1:0]  mode     = 2'h0;
  logic [31:0] rnd      = 32'h0000_65bb;
  logic [31:0] rd;
  logic [15:0] pipe [0:10];

  arcs_link_if link ();

  // Ends under test and checker
  arcs_device #(.CAL_CYCLES (CAL)) i_arcs_device (
    .CORE_CLK    (core_clk),
    .RESET_N     (reset_n),
    .LINK        (link.dev),
    .AVDD_OK     (avdd_ok),
    .DVDD_OK     (dvdd_ok),
    .STRAP_RATIO (arcs_pkg::DIV_BY2),
    .CORE_A      (core_a),
    .CORE_B      (core_b)
  );
  arcs_host #(.TIMEOUT_CYCLES (2000)) i_arcs_host (
    .CORE_CLK (core_clk),
    .RESET_N  (reset_n),
    .LINK     (link.host),
    .WB_CYC_I (wb_cyc),
    .WB_STB_I (wb_stb),
    .WB_WE_I  (wb_we),
    .WB_ADR_I (wb_adr),
    .WB_SEL_I (wb_sel),
    .WB_DAT_I (wb_dat),
    .WB_DAT_O (wb_rdat),
    .WB_ACK_O (wb_ack)
  );
  arcs_asserts #(.CAL_CYCLES (CAL)) i_arcs_asserts (
    .CORE_CLK        (core_clk),
    .RESET_N         (reset_n),
    .recal_low       (link.recal_low),
    .recal_dev_oe_n  (link.recal_dev_oe_n),
    .recal_host_oe_n (link.recal_host_oe_n),
    .sdo_host_oe_n   (link.sdo_host_oe_n),
    .sample_data     (link.sample_data),
    .out_clk         (link.out_clk),
    .reg_rd          (link.reg_rd),
    .reg_ack         (link.reg_ack),
    .div_ovr_en      (link.div_ovr_en),
    .div_ovr_ratio   (link.div_ovr_ratio)
  );

  // Clock of 40 ns, steady for the whole run
  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Upper 16 bits of the two-core sum; the lost bit is truncated
  function automatic logic [15:0] exp_word(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16:1];
  endfunction

  // Random core words and the expected output pipeline
  always @(posedge core_clk)
  begin
    rnd = xs(rnd);
    // Both cores move together; now and then a full-scale corner
    if (rnd[4:0] == 5'h00)
    begin
      core_a <= 16'hFFFF;
      core_b <= 16'hFFFF;
    end
    else
    begin
      core_a <= rnd[15:0];
      core_b <= rnd[31:16];
    end
    pipe[0] <= exp_word(core_a, core_b);
    for (int i = 1; i <= 10; i++)
      pipe[i] <= pipe[i-1];
  end

  // Output word checks on the falling edge, where outputs have settled
  always @(negedge core_clk)
  begin
    if (mode == 2'h1)
      check_pin("sample_data", pipe[10], link.sample_data);
    if (mode == 2'h2)
      check_pin("pattern", arcs_pkg::CAL_PATTERN, link.sample_data);
  end

  task automatic check_pin(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    wb_sel <= sel;
    @(posedge core_clk);
    // Ack is looked at mid-cycle: that is the value the next rising edge samples
    @(negedge core_clk);
    while (wb_ack !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        errors++;
        complete_run();
      end
      @(negedge core_clk);
    end
    rd = wb_rdat;
    @(posedge core_clk);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask

  // Eight CORE_CLK cycles of the output clock: toggling every cycle or held low
  task automatic clk_watch(input logic tog);
    logic p;
    // Reference taken mid-cycle, never in the step of the edge that moves it
    @(negedge core_clk);
    p = link.out_clk;
    repeat (8)
    begin
      @(negedge core_clk);
      check_pin("out_clk", {15'h0, tog & ~p}, {15'h0, link.out_clk});
      p = link.out_clk;
    end
    @(posedge core_clk);
  endtask

  // Poll host status until done and idle, then watch live data
  task automatic settle;
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[1:0] !== 2'b01)
    begin
      n++;
      if (n > 200)
      begin
        errors++;
        complete_run();
      end
      repeat (4) @(posedge core_clk);
      wb(1'b0, arcs_pkg::HOST_STAT_OFS, 32'h0000_0000, 4'hF);
    end
    check_reg("status", 32'h0000_0001, rd);
    mode <= 2'h1;
    repeat (30) @(posedge core_clk);
    mode <= 2'h0;
  endtask

  // Power-on hold, divider override, supplies, then user recalibrations
  initial
  begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check_pin("recal_low", 16'h0000, {15'h0, link.recal_low});
    mode <= 2'h2;
    clk_watch(1'b0);
    for (int c = 0; c < 3; c++)
    begin
      wb(1'b1, arcs_pkg::HOST_CTRL_OFS, 32'(c * 4 + 2), 4'hF);
      repeat (4) @(posedge core_clk);
      clk_watch(c == 0);
    end
    avdd_ok <= 1'b1;
    repeat (20) @(posedge core_clk);
    check_pin("recal_low", 16'h0000, {15'h0, link.recal_low});
    dvdd_ok <= 1'b1;
    repeat (60) @(posedge core_clk);
    mode <= 2'h0;
    settle();
    wb(1'b0, 8'h0C, 32'h0000_0000, 4'hF);
    check_reg("unmapped", 32'h0000_0000, rd);
    wb(1'b1, arcs_pkg::HOST_CTRL_OFS, 32'h0000_0001, 4'hE);
    wb(1'b0, arcs_pkg::HOST_STAT_OFS, 32'h0000_0000, 4'hF);
    check_reg("no start", 32'h0000_0001, rd);
    for (int c = 0; c < 3; c++)
    begin
      wb(1'b1, arcs_pkg::HOST_CTRL_OFS, 32'(c * 4 + 3), 4'hF);
      wb(1'b0, arcs_pkg::HOST_STAT_OFS, 32'h0000_0000, 4'hF);
      check_pin("busy", 16'h0001, {15'h0, rd[arcs_pkg::STAT_BUSY]});
      repeat (8) @(posedge core_clk);
      mode <= 2'h2;
      repeat (100) @(posedge core_clk);
      mode <= 2'h0;
      settle();
    end
    complete_run();
  end

endmodule

// file: sim/arcs_asserts.sv
// Purpose: Concurrent checks on the link between converter end and host end
// Assumes: One clock domain, synchronous active-low reset
// Notes:   CAL_CYCLES must match the converter instance
`timescale 1ns/1ps
module arcs_asserts #(
  parameter int CAL_CYCLES = 200
) (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  // Recalibration line and serial data enable
  input wire logic        recal_low,
  input wire logic        recal_dev_oe_n,
  input wire logic        recal_host_oe_n,
  input wire logic        sdo_host_oe_n,
  // Data, output clock, status link and divider override
  input wire logic [15:0] sample_data,
  input wire logic        out_clk,
  input wire logic        reg_rd,
  input wire logic        reg_ack,
  input wire logic        div_ovr_en,
  input wire logic [1:0]  div_ovr_ratio
);
  // Window for end of calibration; slack covers the line synchroniser
  localparam int DONE_LO = CAL_CYCLES;
  localparam int DONE_HI = CAL_CYCLES + 16;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  // Divider ratios that gate the output clock, and plain ratio one
  wire div_slow = div_ovr_en && (div_ovr_ratio == arcs_pkg::DIV_BY2 || div_ovr_ratio == arcs_pkg::DIV_BY4);
  wire div_one  = div_ovr_en && (div_ovr_ratio == arcs_pkg::DIV_BY1);

  // Steps of a calibration run
  sequence s_rise;
    $rose(recal_low);
  endsequence
  sequence s_pattern_run;
    (sample_data == arcs_pkg::CAL_PATTERN) [*8];
  endsequence

  a_read_ack: assert property (reg_rd |=> reg_ack ##1 !reg_ack)
    else $error("status read not answered in one cycle");
  a_pattern_low: assert property ((!recal_low) [*5] |-> sample_data == arcs_pkg::CAL_PATTERN)
    else $error("pattern missing while line low");
  a_div_hold_low: assert property ((!recal_low && div_slow) [*5] |-> !out_clk)
    else $error("output clock not held low");
  a_div1_toggle: assert property (div_one [*4] |=> out_clk != $past(out_clk))
    else $error("output clock stopped at ratio one");
  a_clk_resume: assert property (div_slow && $rose(recal_low) |-> ##[1:5] out_clk)
    else $error("output clock did not resume");
  a_cal_starts: assert property (s_rise |-> ##3 s_pattern_run)
    else $error("calibration did not start on rise");
  a_cal_done: assert property (s_rise |-> ##[DONE_LO:DONE_HI] (sample_data != arcs_pkg::CAL_PATTERN)
                               or ##[1:DONE_HI] !recal_low)
    else $error("calibration end outside window");
  a_release_kept: assert property ($rose(recal_dev_oe_n) |=> recal_dev_oe_n [*8])
    else $error("converter pulled line again");
  a_pulse_width: assert property ($fell(recal_host_oe_n) |=> !recal_host_oe_n)
    else $error("host pulse shorter than two cycles");
  a_sdo_undriven: assert property (sdo_host_oe_n)
    else $error("host drives serial data out");

endmodule
